//--- design/cem_error_monitor.sv
`timescale 1ns/10ps
`include "cem_params.svh"
module cem_error_monitor #(
    parameter int ADDR_W = 10,
    parameter int LANES = 4
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire cem_pkg::cem_hdr_t hdr_in,
    input wire cem_pkg::cem_pkt_evt_t pkt_evt_in,
    input wire cem_pkg::cem_lane_evt_t [LANES-1:0] lane_evt_in,
    input wire logic hs_request_control_fault_clock_in,
    input wire cem_pkg::cem_temp_t temp_in
);
    import cem_pkg::*;

    logic bus_wait;
    logic [7:0] idx;
    logic take;
    logic rd_take;
    logic wr_take;
    logic [7:0] rd_byte;
    logic [2:0] temp_min;
    logic temp_b7;
    logic temp_b3;
    logic [5:0] rsvd5b;
    logic [7:0] err_cnt;
    logic [3:0] err_flags;
    logic [2:0] lane_flags [LANES];
    logic clk_fault;
    logic [1:0] vchan;
    logic [5:0] dtype;
    logic [15:0] wcount;
    logic [5:0] ecc_byte;
    logic len_change;
    logic [1:0] ctrl;

    // Every property samples on the rising edge and sleeps in reset
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    // Decode: each register owns one aligned word
    assign idx = address_in[9:2];
    assign take = bus_wait & (read_in | write_in);
    assign rd_take = take & read_in;
    assign wr_take = take & write_in & byteenable_in[0];

    // One wait cycle, then a one-cycle answer
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bus_wait <= 1'b1;
        end else if (take) begin
            bus_wait <= 1'b0;
        end else begin
            bus_wait <= 1'b1;
        end
    end
    assign waitrequest_out = bus_wait;

    // A write gets the same one-cycle answer as a read
    AST_BUS_WR: assert property (
        bus_wait && write_in |=> !waitrequest_out ##1 waitrequest_out)
        else $error("bus write answer not one cycle");
    // No answer without a request, so a master never sees a stray ack
    AST_BUS_IDLE: assert property (
        bus_wait && !read_in && !write_in |=> waitrequest_out)
        else $error("bus answered without a request");

    // Read data is latched on the same edge as the read side effects
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            readdata_out <= 32'h0;
        end else if (rd_take) begin
            readdata_out <= {24'h0, rd_byte};
        end
    end

    // Read data stands until the next read is taken
    AST_RD_QUIET: assert property (
        !rd_take |=> $stable(readdata_out))
        else $error("read data changed without a read");

    // Own control: count enable and header capture enable
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl <= `CEM_CTRL_RST;
        end else if (wr_take && idx == `CEM_IDX_CTRL) begin
            ctrl <= writedata_in[1:0];
        end
    end

    // Lowest reading held; a new event beats a clearing read
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            temp_min <= `CEM_TEMP_IDLE;
        end else if (temp_in.temperature_low_limit) begin
            if (rd_take && idx == `CEM_IDX_TEMP) begin
                temp_min <= temp_in.reading; // R1
            end else if (temp_in.reading < temp_min) begin
                temp_min <= temp_in.reading; // R1
            end
        end else if (rd_take && idx == `CEM_IDX_TEMP) begin
            temp_min <= `CEM_TEMP_IDLE; // R1
        end
    end

    // Outside the alarm and without a read the minimum must not move
    AST_TEMP_HOLD: assert property ( // R1
        !temp_in.temperature_low_limit && !(rd_take && idx == `CEM_IDX_TEMP)
        |=> $stable(temp_min))
        else $error("temperature minimum moved while idle");
    // Outside a clearing read, a higher reading never replaces the held minimum
    AST_TEMP_KEEP: assert property ( // R1
        temp_in.temperature_low_limit && temp_in.reading >= temp_min
        && !(rd_take && idx == `CEM_IDX_TEMP) |=> $stable(temp_min))
        else $error("temperature minimum raised");
    // An alarm reading in the clearing cycle wins over the clear
    AST_TEMP_EVT: assert property ( // R1
        rd_take && idx == `CEM_IDX_TEMP && temp_in.temperature_low_limit
        |=> temp_min == $past(temp_in.reading))
        else $error("alarm reading lost in the clearing cycle");

    // Plain storage for the writable reserved bits
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            temp_b7 <= 1'b0;
            temp_b3 <= 1'b0;
            rsvd5b <= 6'h00;
        end else if (wr_take && idx == `CEM_IDX_TEMP) begin
            temp_b7 <= writedata_in[7];
            temp_b3 <= writedata_in[3];
        end else if (wr_take && idx == `CEM_IDX_RSVD5B) begin
            rsvd5b <= writedata_in[7:2];
        end
    end

    // Error count; saturating so a slow reader never sees a small count
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            err_cnt <= 8'h00;
        end else if (rd_take && idx == `CEM_IDX_ERRCNT) begin
            err_cnt <= {7'h00, pkt_evt_in.pkt_err & ctrl[`CEM_CTRL_CNT_EN]}; // R2
        end else if (pkt_evt_in.pkt_err && ctrl[`CEM_CTRL_CNT_EN]
                     && err_cnt != `CEM_CNT_MAX) begin
            err_cnt <= err_cnt + 8'h01; // R2 R17
        end
    end

    // A clearing read with no new error leaves zero
    AST_CNT_CLR: assert property ( // R2
        rd_take && idx == `CEM_IDX_ERRCNT && !pkt_evt_in.pkt_err
        |=> err_cnt == 8'h00)
        else $error("error counter not cleared by read");
    // Without an error or a read the count stands
    AST_CNT_HOLD: assert property ( // R2
        !pkt_evt_in.pkt_err && !(rd_take && idx == `CEM_IDX_ERRCNT)
        |=> $stable(err_cnt))
        else $error("error counter moved without an error");
    // An error in the clearing cycle survives as a count of one
    AST_CNT_EVT: assert property ( // R2
        rd_take && idx == `CEM_IDX_ERRCNT && pkt_evt_in.pkt_err
        && ctrl[`CEM_CTRL_CNT_EN] |=> err_cnt == 8'h01)
        else $error("error lost in the clearing cycle");

    // Sticky packet status; set wins over the clearing read
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            err_flags <= 4'h0;
        end else begin
            err_flags <= ((rd_take && idx == `CEM_IDX_ERRFLG) ? 4'h0
                          : err_flags)
                         | {pkt_evt_in.short_line_flag, // R3
                            pkt_evt_in.payload_check_fail, // R4
                            pkt_evt_in.header_double_fault, // R5
                            pkt_evt_in.header_single_fault}; // R6
        end
    end

    // A clearing read with no new event empties the status
    AST_FLAG_CLR: assert property ( // R3 R4 R5 R6
        rd_take && idx == `CEM_IDX_ERRFLG && !pkt_evt_in.short_line_flag
        && !pkt_evt_in.payload_check_fail && !pkt_evt_in.header_double_fault
        && !pkt_evt_in.header_single_fault |=> err_flags == 4'h0)
        else $error("status flags not cleared by read");

    // Per lane sticky faults, cleared by reading their register
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic clr;
        assign clr = rd_take && idx == ((l < 2) ? `CEM_IDX_LANE01
                                                : `CEM_IDX_LANE23);
        always_ff @(posedge sys_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                lane_flags[l] <= 3'h0;
            end else begin
                lane_flags[l] <= (clr ? 3'h0 : lane_flags[l])
                                 | lane_evt_in[l]; // R7 R8 R9 R10
            end
        end
        // Every pulse on a lane is held until its register is read
        AST_LANE_SET: assert property (@(posedge sys_clk_in) // R7 R8 R9 R10
            disable iff (!nrst_in)
            lane_evt_in[l] != 3'h0
            |=> &(lane_flags[l] | ~$past(lane_evt_in[l])))
            else $error("lane fault not held");
        // A read of the lane register with no new pulse clears the lane
        AST_LANE_CLR: assert property (@(posedge sys_clk_in) // R7 R8 R9 R10
            disable iff (!nrst_in)
            clr && lane_evt_in[l] == 3'h0 |=> lane_flags[l] == 3'h0)
            else $error("lane fault not cleared by read");
    end

    // Clock lane fault, same sticky scheme
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clk_fault <= 1'b0;
        end else begin
            clk_fault <= ((rd_take && idx == `CEM_IDX_CLKLN) ? 1'b0
                          : clk_fault) | hs_request_control_fault_clock_in; // R11
        end
    end

    // Reading the clock lane register clears it unless a fault lands
    AST_CLK_CLR: assert property ( // R11
        rd_take && idx == `CEM_IDX_CLKLN && !hs_request_control_fault_clock_in
        |=> !clk_fault)
        else $error("clock lane fault not cleared by read");

    // Header capture from long packets only
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            vchan <= 2'h0;
            dtype <= 6'h00;
            wcount <= 16'h0000;
            ecc_byte <= 6'h00;
        end else if (hdr_in.hdr_valid && hdr_in.hdr_long
                     && ctrl[`CEM_CTRL_CAP_EN]) begin
            vchan <= hdr_in.captured_virtual_channel; // R12 R16
            dtype <= hdr_in.captured_data_type; // R12 R16
            wcount <= hdr_in.word_count; // R13 R16
            ecc_byte <= hdr_in.header_ecc; // R14 R16
        end
    end

    // Data type and ECC byte follow the captured long header
    AST_HDR_DT: assert property ( // R12 R14
        hdr_in.hdr_valid && hdr_in.hdr_long && ctrl[`CEM_CTRL_CAP_EN]
        |=> dtype == $past(hdr_in.captured_data_type)
        && ecc_byte == $past(hdr_in.header_ecc))
        else $error("header type or ECC not captured");
    // A short header or a disabled capture leaves channel, word count and ECC alone
    AST_HDR_SHORT: assert property ( // R16
        hdr_in.hdr_valid && (!hdr_in.hdr_long || !ctrl[`CEM_CTRL_CAP_EN])
        |=> $stable(vchan) && $stable(wcount) && $stable(ecc_byte))
        else $error("header changed on a short packet");

    // Line length change, sticky until the ECC register is read
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            len_change <= 1'b0;
        end else begin
            len_change <= ((rd_take && idx == `CEM_IDX_ECC) ? 1'b0
                           : len_change) | pkt_evt_in.line_change; // R15
        end
    end

    // Reading the ECC register clears the change flag unless one lands
    AST_LEN_CLR: assert property ( // R15
        rd_take && idx == `CEM_IDX_ECC && !pkt_evt_in.line_change
        |=> !len_change)
        else $error("line change flag not cleared by read");

    // Read mux; unmapped words read zero
    always_comb begin
        case (idx)
            `CEM_IDX_TEMP: rd_byte = {temp_b7, 3'h0, temp_b3, temp_min};
            `CEM_IDX_RSVD5B: rd_byte = {rsvd5b, 2'h0};
            `CEM_IDX_ERRCNT: rd_byte = err_cnt;
            `CEM_IDX_ERRFLG: rd_byte = {4'h0, err_flags};
            `CEM_IDX_LANE01: rd_byte = {lane_flags[1], 1'b0,
                                        lane_flags[0], 1'b0}; // R7 R8 R9
            `CEM_IDX_LANE23: rd_byte = {lane_flags[3], 1'b0,
                                        lane_flags[2], 1'b0}; // R10
            `CEM_IDX_CLKLN: rd_byte = {6'h00, clk_fault, 1'b0}; // R11
            `CEM_IDX_HDRID: rd_byte = {vchan, dtype}; // R12
            `CEM_IDX_WCLO: rd_byte = wcount[7:0]; // R13
            `CEM_IDX_WCHI: rd_byte = wcount[15:8]; // R13
            `CEM_IDX_ECC: rd_byte = {len_change, 1'b0, ecc_byte}; // R14 R15
            `CEM_IDX_CTRL: rd_byte = {6'h00, ctrl};
            default: rd_byte = 8'h00;
        endcase
    end

    AST_TEMP_CLEAR: assert property ( // R1
        rd_take && idx == `CEM_IDX_TEMP && !temp_in.temperature_low_limit
        |=> temp_min == 3'h7)
        else $error("temperature minimum not cleared by read");
    AST_TEMP_MIN: assert property ( // R1
        temp_in.temperature_low_limit && temp_in.reading < temp_min
        |=> temp_min == $past(temp_in.reading))
        else $error("temperature minimum not captured");
    AST_CNT_INC: assert property ( // R2
        !(rd_take && idx == `CEM_IDX_ERRCNT) && pkt_evt_in.pkt_err
        && ctrl[0] && err_cnt != 8'hFF |=> err_cnt == $past(err_cnt) + 8'h01)
        else $error("error counter did not advance");
    AST_CNT_SAT: assert property ( // R17
        err_cnt == 8'hFF && !(rd_take && idx == `CEM_IDX_ERRCNT)
        |=> err_cnt == 8'hFF)
        else $error("error counter wrapped");
    AST_SHORT: assert property ( // R3
        pkt_evt_in.short_line_flag |=> err_flags[3])
        else $error("short line flag missing");
    AST_CHK: assert property ( // R4
        pkt_evt_in.payload_check_fail |=> err_flags[2])
        else $error("checksum flag missing");
    AST_DBL: assert property ( // R5
        pkt_evt_in.header_double_fault |=> err_flags[1])
        else $error("double fault flag missing");
    AST_SGL: assert property ( // R6
        pkt_evt_in.header_single_fault |=> err_flags[0])
        else $error("single fault flag missing");
    AST_LANE0: assert property ( // R7
        rd_take && idx == `CEM_IDX_LANE01 && lane_flags[0][2]
        |=> readdata_out[3])
        else $error("lane 0 sync fault not reported");
    AST_CLK: assert property ( // R11
        hs_request_control_fault_clock_in |=> clk_fault)
        else $error("clock lane fault missing");
    AST_HDR: assert property ( // R12
        hdr_in.hdr_valid && hdr_in.hdr_long && ctrl[1]
        |=> vchan == $past(hdr_in.captured_virtual_channel)
        && wcount == $past(hdr_in.word_count))
        else $error("header not captured");
    AST_HOLD: assert property ( // R16
        !hdr_in.hdr_valid |=> $stable(wcount) && $stable(dtype))
        else $error("header changed without a packet");
    AST_LEN: assert property ( // R15
        pkt_evt_in.line_change |=> len_change)
        else $error("line change flag missing");
    AST_BUS: assert property (
        bus_wait && read_in |=> !waitrequest_out ##1 waitrequest_out)
        else $error("bus answer not one cycle");
endmodule : cem_error_monitor

//--- design/cem_params.svh
`ifndef CEM_PARAMS_SVH
`define CEM_PARAMS_SVH
// Behaviour
// (R1) Hold lowest temperature under low limit in 3 bits; 7 is idle; read clears.
// (R2) Count erroneous received packets in 8 bits; a read clears the count.
// (R3) Status bit 3 sets when a line is shorter than header count.
// (R4) Status bit 2 sets on an uncorrectable payload checksum error.
// (R5) Status bit 1 sets on a two-bit header ECC error.
// (R6) Status bit 0 sets on a single-bit header ECC error.
// (R7) Lanes 1 and 0 report correctable sync faults at bits 7 and 3.
// (R8) Lanes 1 and 0 report multi-bit sync faults at bits 6 and 2.
// (R9) Lanes 1 and 0 report request control faults at bits 5 and 1.
// (R10) Lanes 3 and 2 use the same layout in the next register.
// (R11) Clock lane request control fault sits at bit 1, rest reserved.
// (R12) Header virtual channel in bits 7:6, data type in 5:0.
// (R13) Header word count low and high bytes in consecutive registers.
// (R14) Header ECC byte shown in bits 5:0 of its register.
// (R15) Bit 7 of the ECC register flags a line length change.
// (R16) Header fields follow the latest long packet, else stay unchanged.
// (R17) Error counter saturates at its maximum instead of wrapping.

// Register indices; byte address is four times the index
`define CEM_IDX_TEMP 8'h5A
`define CEM_IDX_RSVD5B 8'h5B
`define CEM_IDX_ERRCNT 8'h5C
`define CEM_IDX_ERRFLG 8'h5D
`define CEM_IDX_LANE01 8'h5E
`define CEM_IDX_LANE23 8'h5F
`define CEM_IDX_CLKLN 8'h60
`define CEM_IDX_HDRID 8'h61
`define CEM_IDX_WCLO 8'h62
`define CEM_IDX_WCHI 8'h63
`define CEM_IDX_ECC 8'h64
`define CEM_IDX_CTRL 8'h70
// Field positions
`define CEM_ERR_SHORT 3
`define CEM_ERR_CHK 2
`define CEM_ERR_DBL 1
`define CEM_ERR_SGL 0
`define CEM_ECC_CHG 7
`define CEM_CTRL_CNT_EN 0
`define CEM_CTRL_CAP_EN 1
// Reset and saturation values
`define CEM_TEMP_IDLE 3'h7
`define CEM_CNT_MAX 8'hFF
`define CEM_CTRL_RST 2'h3
`endif

//--- design/cem_pkg.sv
package cem_pkg;
    // Received packet header as decoded by the receive path
    typedef struct packed {
        logic hdr_valid;
        logic hdr_long;
        logic [1:0] captured_virtual_channel;
        logic [5:0] captured_data_type;
        logic [15:0] word_count;
        logic [5:0] header_ecc;
    } cem_hdr_t;
    // One-cycle packet level error pulses
    typedef struct packed {
        logic pkt_err;
        logic short_line_flag;
        logic payload_check_fail;
        logic header_double_fault;
        logic header_single_fault;
        logic line_change;
    } cem_pkt_evt_t;
    // One-cycle per lane fault pulses
    typedef struct packed {
        logic sync_single_fault_lane;
        logic sync_multi_fault_lane;
        logic hs_request_control_fault_lane;
    } cem_lane_evt_t;
    // Temperature alarm input
    typedef struct packed {
        logic temperature_low_limit;
        logic [2:0] reading;
    } cem_temp_t;
endpackage : cem_pkg

//--- test/cem_sensor_model.sv
`timescale 1ns/10ps
module cem_sensor_model (
    input wire logic sys_clk_in,
    output cem_pkg::cem_hdr_t hdr_out,
    output cem_pkg::cem_pkt_evt_t pkt_evt_out,
    output cem_pkg::cem_lane_evt_t [3:0] lane_evt_out,
    output logic clk_fault_out,
    output cem_pkg::cem_temp_t temp_out
);
    import cem_pkg::*;
    // Quiet link, no alarm; stale header fields show a pattern
    initial begin
        hdr_out = 32'h3FFFFFFF;
        pkt_evt_out = 6'h00;
        lane_evt_out = 12'h000;
        clk_fault_out = 1'h0;
        temp_out = 4'h7;
    end
    // One header strobe; fields flip afterwards so stale data never looks valid
    task automatic send_hdr(input logic lng, input logic [29:0] f);
        hdr_out <= {1'h1, lng, f};
        @(posedge sys_clk_in);
        hdr_out <= {1'h0, lng, ~f};
        @(posedge sys_clk_in);
    endtask : send_hdr
    // One-cycle fault pulses, then an idle cycle so calls never merge
    task automatic evt(input logic [5:0] p, input logic [11:0] ln,
                       input logic ck);
        pkt_evt_out <= p;
        lane_evt_out <= ln;
        clk_fault_out <= ck;
        @(posedge sys_clk_in);
        pkt_evt_out <= 6'h00;
        lane_evt_out <= 12'h000;
        clk_fault_out <= 1'h0;
        @(posedge sys_clk_in);
    endtask : evt
    // Level alarm; reading is meaningless while not below the limit
    task automatic temp(input logic below, input logic [2:0] r);
        temp_out <= {below, below ? r : ~r};
    endtask : temp
endmodule : cem_sensor_model

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
    import cem_pkg::*;
    logic sys_clk_in = 1'h0;
    logic nrst_in = 1'h0;
    logic [9:0] address_in = 10'h000;
    logic read_in = 1'h0;
    logic write_in = 1'h0;
    logic [31:0] writedata_in = 32'h0;
    logic [31:0] readdata_out;
    logic waitrequest_out;
    cem_hdr_t hdr;
    cem_pkt_evt_t pkt_evt;
    cem_lane_evt_t [3:0] lane_evt;
    logic clk_fault;
    cem_temp_t temp;
    int num_errors = 0;
    int tests_run = 0;
    logic [7:0] rd;
    // 250 MHz system clock
    always #2 sys_clk_in = ~sys_clk_in;
    cem_error_monitor dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .address_in(address_in), .read_in(read_in), .write_in(write_in),
        .writedata_in(writedata_in), .byteenable_in(4'hF),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
        .hdr_in(hdr), .pkt_evt_in(pkt_evt), .lane_evt_in(lane_evt),
        .hs_request_control_fault_clock_in(clk_fault), .temp_in(temp));
    cem_sensor_model model (.sys_clk_in(sys_clk_in), .hdr_out(hdr),
        .pkt_evt_out(pkt_evt), .lane_evt_out(lane_evt),
        .clk_fault_out(clk_fault), .temp_out(temp));
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Avalon access; request held until waitrequest is seen low at a
    // rising edge, where read data is taken and the request dropped
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        address_in <= {idx, 2'h0};
        read_in <= ~wr;
        write_in <= wr;
        writedata_in <= {24'h0, wd};
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (waitrequest_out !== 1'h0 && n < 50);
        if (n >= 50) begin
            num_errors++;
        end
        q = readdata_out[7:0];
        read_in <= 1'h0;
        write_in <= 1'h0;
    endtask : bus
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'h0, idx, 8'h00, rd);
        chk($sformatf("reg %h", idx), rd, exp);
    endtask : rd_chk
    // Reset values, read-only and unmapped places
    task automatic t_reset;
        for (int i = 0; i < 11; i++) begin
            rd_chk(8'h5A + 8'(i), (i == 0) ? 8'h07 : 8'h00);
        end
        bus(1'h1, 8'h5E, 8'hFF, rd);
        rd_chk(8'h5E, 8'h00);
        bus(1'h1, 8'h5B, 8'hFF, rd);
        rd_chk(8'h5B, 8'hFC);
        bus(1'h1, 8'h65, 8'hFF, rd);
        rd_chk(8'h65, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    // Status bits one at a time, then counter and its clear on read
    task automatic t_pkt;
        for (int i = 0; i < 4; i++) begin
            model.evt(6'h02 << i, 12'h000, 1'h0);
            rd_chk(8'h5D, 8'h01 << i);
            rd_chk(8'h5D, 8'h00);
        end
        repeat (3) model.evt(6'h20, 12'h000, 1'h0);
        rd_chk(8'h5C, 8'h03);
        rd_chk(8'h5C, 8'h00);
        repeat (260) model.evt(6'h20, 12'h000, 1'h0);
        rd_chk(8'h5C, 8'hFF);
        $display("t_pkt done");
    endtask : t_pkt
    // Each lane fault kind on each lane, then the clock lane
    task automatic t_lanes;
        logic [7:0] idx;
        for (int l = 0; l < 4; l++) begin
            for (int k = 0; k < 3; k++) begin
                idx = (l < 2) ? 8'h5E : 8'h5F;
                model.evt(6'h00, 12'h001 << (3 * l + 2 - k), 1'h0);
                rd_chk(idx, 8'h01 << ((l % 2) * 4 + 3 - k));
                rd_chk(idx, 8'h00);
            end
        end
        model.evt(6'h00, 12'h000, 1'h1);
        rd_chk(8'h60, 8'h02);
        rd_chk(8'h60, 8'h00);
        $display("t_lanes done");
    endtask : t_lanes
    // Long header captured, short header ignored, line change flag
    task automatic t_hdr;
        model.send_hdr(1'h1, {2'h2, 6'h2B, 16'hA5C3, 6'h15});
        model.send_hdr(1'h0, {2'h1, 6'h11, 16'h1234, 6'h2A});
        rd_chk(8'h61, 8'hAB);
        rd_chk(8'h62, 8'hC3);
        rd_chk(8'h63, 8'hA5);
        rd_chk(8'h64, 8'h15);
        model.evt(6'h01, 12'h000, 1'h0);
        rd_chk(8'h64, 8'h95);
        $display("t_hdr done");
    endtask : t_hdr
    // Control bits off: no counting, no capture; then counting again
    task automatic t_ctrl;
        rd_chk(8'h70, 8'h03);
        bus(1'h1, 8'h70, 8'h00, rd);
        rd_chk(8'h70, 8'h00);
        model.evt(6'h20, 12'h000, 1'h0);
        model.send_hdr(1'h1, {2'h1, 6'h11, 16'h1234, 6'h2A});
        rd_chk(8'h5C, 8'h00);
        rd_chk(8'h61, 8'hAB);
        rd_chk(8'h62, 8'hC3);
        bus(1'h1, 8'h70, 8'h03, rd);
        model.evt(6'h20, 12'h000, 1'h0);
        rd_chk(8'h5C, 8'h01);
        $display("t_ctrl done");
    endtask : t_ctrl
    // Lowest reading kept while under the limit; read returns it to idle
    task automatic t_temp;
        model.temp(1'h1, 3'h5);
        repeat (3) @(posedge sys_clk_in);
        model.temp(1'h1, 3'h3);
        repeat (3) @(posedge sys_clk_in);
        model.temp(1'h1, 3'h6);
        repeat (3) @(posedge sys_clk_in);
        model.temp(1'h0, 3'h0);
        rd_chk(8'h5A, 8'h03);
        rd_chk(8'h5A, 8'h07);
        $display("t_temp done");
    endtask : t_temp
    // Whole run is under a thousand cycles; far beyond that means a hang
    initial begin
        #80000;
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge sys_clk_in);
        nrst_in <= 1'h1;
        t_reset();
        t_pkt();
        t_lanes();
        t_hdr();
        t_ctrl();
        t_temp();
        end_sim();
    end
endmodule : tb
